// [logic/isd_pkg.sv]
package isd_pkg;
  // opcode classes, fixed by upper nibble and fields
  localparam logic [3:0] OPC_JUMP_SHORT = 4'h8;
  localparam logic [3:0] OPC_GRP5 = 4'h5;
  localparam logic [3:0] OPC_GRP1 = 4'h1;
  localparam logic [3:0] OPC_GRP3 = 4'h3;
  localparam logic [15:0] OPC_INTERRUPT_RETURN = 16'h5FD7;
  localparam logic [15:0] OPC_STOP = 16'h179F;
  localparam logic [15:0] OPC_IDLE = 16'h171F;
  localparam logic [15:0] OPC_PUSH_MULTI = 16'h1F9E;
  localparam logic [15:0] OPC_POP_MULTI = 16'h1796;
  localparam logic [3:0] SUB_MUL_SIGNED = 4'hB;
  localparam logic [3:0] SUB_MUL_UNSIGNED = 4'h9;
  localparam logic [3:0] SUB_JUMP_LONG_LO = 4'h7;
  localparam logic [3:0] SUB_JUMP_LONG_MID = 4'h9;
  localparam logic [3:0] CONDITION_FIELD_ALWAYS = 4'hF;
  // cycle counts, pc steps and reset values
  localparam logic [7:0] CYC_JUMP_LONG_TAKEN = 8'h09;
  localparam logic [7:0] CYC_JUMP_LONG_NOT = 8'h06;
  localparam logic [7:0] CYC_JUMP_SHORT_TAKEN = 8'h07;
  localparam logic [7:0] CYC_JUMP_SHORT_NOT = 8'h04;
  localparam logic [7:0] CYC_LEA = 8'h06;
  localparam logic [7:0] CYC_PUSH_BASE = 8'h07;
  localparam logic [7:0] CYC_POP_BASE = 8'h09;
  localparam logic [7:0] CYC_PER_REG = 8'h03;
  localparam logic [7:0] CYC_MUL = 8'h15;
  localparam logic [7:0] CYC_NEG_BORROW = 8'h03;
  localparam logic [7:0] CYC_INT_RETURN = 8'h0C;
  localparam logic [15:0] PC_STEP_JUMP = 16'h0004;
  localparam logic [15:0] PC_STEP_ONE = 16'h0002;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_SP = 16'h0000;

  typedef enum logic [2:0] {
    ISD_IDLE = 3'b000,
    ISD_EXEC = 3'b001,
    ISD_POP_SR = 3'b010,
    ISD_POP_PC = 3'b011,
    ISD_SLEEP = 3'b100
  } isd_state_t;

  // datapath command toward register file and stack
  typedef struct packed {
    logic reg_we;
    logic [3:0] reg_idx;
    logic [15:0] reg_data;
    logic stack_we;
    logic stack_re;
    logic [15:0] stack_addr;
    logic [15:0] stack_data;
  } isd_dp_cmd_t;

  typedef struct packed {
    isd_state_t state;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] status_word;
    logic [7:0] cycles;
    logic [15:0] reg_list;
    logic is_push;
    logic is_mul;
    logic [15:0] mul_lo;
    logic [1:0] insn_len;
    logic done;
    logic cpu_clk_en;
    logic io_clk_en;
    logic fetch_ready;
    logic busy;
    isd_dp_cmd_t cmd;
  } isd_state_s_t;
endpackage

// [logic/isd_decoder.sv]
`timescale 1ns/1ps
// How it works
// RULE_01: long conditional jump, taken 9, else 6
// RULE_02: jump base is jump's own address; code adds PC_STEP_JUMP (4) to it
// RULE_03: 16-bit displacement is two's complement
// RULE_04: 9-bit displacement signed magnitude, doubled
// RULE_05: indexed address base plus scaled index plus offset
// RULE_06: software keeps index and destination distinct
// RULE_07: software lists at least two registers
// RULE_08: push pre-decrements, seven plus three each
// RULE_09: pop post-increments, nine plus three each
// RULE_10: multiply pair, high even, 21, flags kept
// RULE_11: negate with borrow, zero minus dst minus carry
// RULE_12: interrupt return pops status then pc, 12
// RULE_13: stop gates cpu and io clocks
// RULE_14: idle advances pc, cpu clocks off only
// RULE_15: report instruction length in words
module isd_decoder
  import isd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic insn_valid_in,
  input wire logic [15:0] insn_word_in,
  input wire logic [15:0] ext1_in,
  input wire logic [15:0] ext2_in,
  input wire logic condition_field_true_in,
  input wire logic carry_in,
  input wire logic [15:0] reg_a_in,
  input wire logic [15:0] reg_b_in,
  input wire logic [15:0] reg_c_in,
  input wire logic [15:0] stack_rdata_in,
  input wire logic wake_in,
  output logic fetch_ready_out,
  output logic [1:0] insn_len_out,
  output logic [15:0] pc_out,
  output logic [15:0] sp_out,
  output logic [15:0] status_word_out,
  output logic busy_out,
  output logic done_out,
  output logic cpu_clk_en_out,
  output logic io_clk_en_out,
  output isd_dp_cmd_t dp_cmd_out
);
  isd_state_s_t s_q, s_d;

  function automatic logic [7:0] count_regs(input logic [15:0] l);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      n = n + {7'h00, l[i]};
    end
    return n;
  endfunction

  function automatic logic [3:0] first_reg(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (l[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  logic [3:0] op_hi, op_sub, op_lo;
  logic [15:0] d9_ext, prod_lo, prod_hi;
  logic [31:0] prod;
  logic take_insn;
  assign op_hi = insn_word_in[15:12];
  assign op_sub = insn_word_in[7:4];
  assign op_lo = insn_word_in[3:0];
  // signed magnitude: bit8 sign, bits7:0 magnitude, doubled
  assign d9_ext = insn_word_in[8] ? (16'h0000 - {7'h00, insn_word_in[7:0], 1'b0})
                                  : {7'h00, insn_word_in[7:0], 1'b0}; // RULE_04
  assign prod = insn_word_in[5]
                ? {{16{reg_a_in[15]}}, reg_a_in} * {{16{reg_b_in[15]}}, reg_b_in}
                : {16'h0000, reg_a_in} * {16'h0000, reg_b_in}; // RULE_10
  assign prod_hi = prod[31:16];
  assign prod_lo = prod[15:0];
  assign take_insn = (s_q.state == ISD_IDLE) && s_q.fetch_ready && insn_valid_in;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.cmd.reg_we = 1'b0;
    s_d.cmd.stack_we = 1'b0;
    s_d.cmd.stack_re = 1'b0;
    unique case (s_q.state)
      ISD_IDLE:
      begin
        s_d.fetch_ready = 1'b1;
        if (take_insn)
        begin
          s_d.fetch_ready = 1'b0;
          s_d.state = ISD_EXEC;
          s_d.insn_len = 2'd1;
          s_d.cycles = CYC_NEG_BORROW;
          s_d.pc = s_q.pc + PC_STEP_ONE;
          s_d.reg_list = 16'h0000;
          s_d.is_mul = 1'b0;
          if (op_hi == OPC_JUMP_SHORT)
          begin
            if (insn_word_in[11:8] == CONDITION_FIELD_ALWAYS || condition_field_true_in)
            begin
              s_d.pc = s_q.pc + PC_STEP_JUMP + d9_ext; // RULE_02
              s_d.cycles = CYC_JUMP_SHORT_TAKEN;
            end
            else
            begin
              s_d.cycles = CYC_JUMP_SHORT_NOT;
            end
          end
          else if (op_hi == OPC_GRP5 && op_sub == SUB_JUMP_LONG_MID
                   && op_lo == SUB_JUMP_LONG_LO)
          begin
            s_d.insn_len = 2'd2; // RULE_15
            s_d.pc = s_q.pc + PC_STEP_JUMP;
            s_d.cycles = CYC_JUMP_LONG_NOT; // RULE_01
            if (insn_word_in[11:8] == CONDITION_FIELD_ALWAYS || condition_field_true_in)
            begin
              s_d.pc = s_q.pc + PC_STEP_JUMP + ext1_in; // RULE_03
              s_d.cycles = CYC_JUMP_LONG_TAKEN; // RULE_01
            end
          end
          else if (insn_word_in == OPC_INTERRUPT_RETURN)
          begin
            s_d.state = ISD_POP_SR; // RULE_12
            s_d.cycles = CYC_INT_RETURN;
            s_d.cmd.stack_re = 1'b1;
            s_d.cmd.stack_addr = s_q.sp;
            s_d.sp = s_q.sp + PC_STEP_ONE;
            s_d.pc = s_q.pc;
          end
          else if (insn_word_in == OPC_STOP)
          begin
            s_d.state = ISD_SLEEP;
            s_d.cpu_clk_en = 1'b0; // RULE_13
            s_d.io_clk_en = 1'b0; // RULE_13
          end
          else if (insn_word_in == OPC_IDLE)
          begin
            s_d.state = ISD_SLEEP; // RULE_14
            s_d.cpu_clk_en = 1'b0;
          end
          else if (insn_word_in == OPC_PUSH_MULTI || insn_word_in == OPC_POP_MULTI)
          begin
            s_d.insn_len = 2'd2;
            s_d.reg_list = ext1_in;
            s_d.is_push = (insn_word_in == OPC_PUSH_MULTI);
            s_d.cycles = (insn_word_in == OPC_PUSH_MULTI)
                         ? CYC_PUSH_BASE + CYC_PER_REG * count_regs(ext1_in) // RULE_08
                         : CYC_POP_BASE + CYC_PER_REG * count_regs(ext1_in); // RULE_09
          end
          else if (op_hi == OPC_GRP5 && (op_sub == SUB_MUL_SIGNED
                   || op_sub == SUB_MUL_UNSIGNED) && !insn_word_in[0])
          begin
            // even reg gets high word now, odd gets low word later; flags untouched
            s_d.cycles = CYC_MUL; // RULE_10
            s_d.cmd.reg_we = 1'b1;
            s_d.cmd.reg_idx = insn_word_in[3:0];
            s_d.cmd.reg_data = prod_hi;
            s_d.mul_lo = prod_lo;
            s_d.is_mul = 1'b1;
            s_d.reg_list = 16'h0001 << {insn_word_in[3:1], 1'b1};
          end
          else if (op_hi == OPC_GRP1 && op_lo == 4'h1 || op_hi == OPC_GRP1
                   && insn_word_in[7:6] == 2'b11)
          begin
            s_d.insn_len = 2'd2;
            s_d.cycles = CYC_LEA; // RULE_05
            s_d.cmd.reg_we = 1'b1;
            s_d.cmd.reg_idx = {1'b0, insn_word_in[6:4]};
            s_d.cmd.reg_data = reg_c_in + (insn_word_in[7] ? {reg_a_in[14:0], 1'b0}
                               : reg_a_in) + ext1_in; // RULE_05
          end
          else if (op_hi == OPC_GRP3 && insn_word_in[11:8] == 4'h7
                   && insn_word_in[6:4] == 3'b110)
          begin
            s_d.cmd.reg_we = 1'b1; // RULE_11
            s_d.cmd.reg_idx = op_lo;
            s_d.cmd.reg_data = 16'h0000 - reg_a_in - {15'h0000, carry_in}; // RULE_11
          end
        end
      end
      ISD_EXEC:
      begin
        s_d.cycles = s_q.cycles - 8'h01;
        if (s_q.cmd.stack_re)
        begin
          s_d.cmd.reg_we = 1'b1; // RULE_09
          s_d.cmd.reg_data = stack_rdata_in;
        end
        if (s_q.reg_list != 16'h0000 && s_q.cycles % CYC_PER_REG == 8'h00)
        begin
          if (s_q.is_mul)
          begin
            s_d.cmd.reg_we = 1'b1;
            s_d.cmd.reg_idx = first_reg(s_q.reg_list);
            s_d.cmd.reg_data = s_q.mul_lo; // RULE_10
          end
          else if (s_q.is_push)
          begin
            s_d.sp = s_q.sp - PC_STEP_ONE; // RULE_08
            s_d.cmd.stack_we = 1'b1;
            s_d.cmd.stack_addr = s_q.sp - PC_STEP_ONE;
            s_d.cmd.stack_data = reg_b_in;
            s_d.cmd.reg_idx = first_reg(s_q.reg_list);
          end
          else
          begin
            s_d.cmd.stack_re = 1'b1; // RULE_09
            s_d.cmd.stack_addr = s_q.sp;
            s_d.sp = s_q.sp + PC_STEP_ONE;
            s_d.cmd.reg_idx = first_reg(s_q.reg_list);
          end
          s_d.reg_list = s_q.reg_list & (s_q.reg_list - 16'h0001);
        end
        if (s_q.cycles <= 8'h02)
        begin
          s_d.state = ISD_IDLE;
          s_d.done = 1'b1;
          s_d.fetch_ready = 1'b1;
        end
      end
      ISD_POP_SR:
      begin
        s_d.status_word = stack_rdata_in; // RULE_12
        s_d.cmd.stack_re = 1'b1;
        s_d.cmd.stack_addr = s_q.sp;
        s_d.sp = s_q.sp + PC_STEP_ONE;
        s_d.cycles = s_q.cycles - 8'h01;
        s_d.state = ISD_POP_PC;
      end
      ISD_POP_PC:
      begin
        s_d.pc = stack_rdata_in; // RULE_12
        s_d.cycles = s_q.cycles - 8'h01;
        s_d.state = ISD_EXEC;
      end
      ISD_SLEEP:
      begin
        s_d.fetch_ready = 1'b0;
        if (wake_in)
        begin
          s_d.cpu_clk_en = 1'b1;
          s_d.io_clk_en = 1'b1;
          s_d.state = ISD_IDLE;
        end
      end
      default:
      begin
        s_d.state = ISD_IDLE;
      end
    endcase
    s_d.busy = (s_d.state != ISD_IDLE);
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q <= '0;
      s_q.state <= ISD_IDLE;
      s_q.pc <= RESET_PC;
      s_q.sp <= RESET_SP;
      s_q.cpu_clk_en <= 1'b1;
      s_q.io_clk_en <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign fetch_ready_out = s_q.fetch_ready;
  assign insn_len_out = s_q.insn_len;
  assign pc_out = s_q.pc;
  assign sp_out = s_q.sp;
  assign status_word_out = s_q.status_word;
  assign busy_out = s_q.busy;
  assign done_out = s_q.done;
  assign cpu_clk_en_out = s_q.cpu_clk_en;
  assign io_clk_en_out = s_q.io_clk_en;
  assign dp_cmd_out = s_q.cmd;

  property p_stop_gates;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (take_insn && insn_word_in == OPC_STOP)
      |=> !cpu_clk_en_out && !io_clk_en_out;
  endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("stop left a clock running"); // RULE_13

  property p_idle_io;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (take_insn && insn_word_in == OPC_IDLE)
      |=> !cpu_clk_en_out && io_clk_en_out && pc_out == $past(pc_out) + PC_STEP_ONE;
  endproperty
  a_idle_io: assert property (p_idle_io) else $error("idle gating or pc wrong"); // RULE_14

  property p_ret_order;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (take_insn && insn_word_in == OPC_INTERRUPT_RETURN)
      |=> s_q.state == ISD_POP_SR ##1 s_q.state == ISD_POP_PC;
  endproperty
  a_ret_order: assert property (p_ret_order) else $error("return pop order wrong"); // RULE_12

  property p_long_taken;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (take_insn && op_hi == OPC_GRP5
     && op_sub == SUB_JUMP_LONG_MID && op_lo == SUB_JUMP_LONG_LO && condition_field_true_in)
      |=> pc_out == $past(pc_out) + PC_STEP_JUMP + $past(ext1_in) && insn_len_out == 2'd2;
  endproperty
  a_long_taken: assert property (p_long_taken) else $error("long jump target wrong"); // RULE_01

  property p_neg;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (take_insn && op_hi == OPC_GRP3 && insn_word_in[11:8] == 4'h7
     && insn_word_in[6:4] == 3'b110)
      |=> dp_cmd_out.reg_we && dp_cmd_out.reg_data == 16'h0000 - $past(reg_a_in)
          - {15'h0000, $past(carry_in)};
  endproperty
  a_neg: assert property (p_neg) else $error("negate with borrow result wrong"); // RULE_11

  property p_push_pre;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    dp_cmd_out.stack_we |-> dp_cmd_out.stack_addr == sp_out;
  endproperty
  a_push_pre: assert property (p_push_pre) else $error("push slot not pre-decremented"); // RULE_08

  c_stop: cover property (@(posedge clk_sys_in) s_q.state == ISD_SLEEP);
  c_ret: cover property (@(posedge clk_sys_in) s_q.state == ISD_POP_PC);
  c_done: cover property (@(posedge clk_sys_in) done_out);
endmodule

// [tb/isd_stack_model.sv]
`timescale 1ns/1ps
module isd_stack_model
  import isd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire isd_dp_cmd_t dp_cmd_in,
  output logic [15:0] stack_rdata_out
);
  logic [15:0] mem_q [0:127];
  logic [15:0] last_q;

  // preset pattern so each slot is recognisable
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem_q[i] = 16'h5A00 + 16'(2 * i);
    last_q = 16'h0000;
  end

  always @(posedge clk_sys_in)
  begin
    if (dp_cmd_in.stack_we === 1'b1)
      mem_q[dp_cmd_in.stack_addr[7:1]] <= dp_cmd_in.stack_data;
    if (dp_cmd_in.stack_re === 1'b1)
      last_q <= mem_q[dp_cmd_in.stack_addr[7:1]];
  end

  // released read bus shows the inverse of the last word
  assign stack_rdata_out = (dp_cmd_in.stack_re === 1'b1) ?
    mem_q[dp_cmd_in.stack_addr[7:1]] : ~last_q;
endmodule

// [tb/tb_cpu_instruction_semantics_decoder.sv]
`timescale 1ns/1ps
module tb_cpu_instruction_semantics_decoder
  import isd_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic insn_valid_in = 1'b0;
  logic [15:0] insn_word_in = 16'h0000;
  logic [15:0] ext1_in = 16'h0000;
  logic condition_field_true_in = 1'b0;
  logic [15:0] reg_a_in = 16'h0000;
  logic [15:0] reg_b_in = 16'hBEEF;
  logic [15:0] reg_c_in = 16'h1000;
  logic carry_in = 1'b0;
  logic wake_in = 1'b0;
  logic [15:0] stack_rdata_in;
  logic fetch_ready_out;
  logic [1:0] insn_len_out;
  logic [15:0] pc_out;
  logic [15:0] sp_out;
  logic [15:0] status_word_out;
  logic done_out;
  logic cpu_clk_en_out;
  logic io_clk_en_out;
  isd_dp_cmd_t dp_cmd_out;
  logic [15:0] reg_seen [0:15];
  int err_count = 0;
  int checked = 0;
  int ct;
  int cn;

  always #50 clk_sys_in = ~clk_sys_in;

  isd_decoder uut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .insn_valid_in(insn_valid_in), .insn_word_in(insn_word_in),
    .ext1_in(ext1_in), .ext2_in(16'h0000), .condition_field_true_in(condition_field_true_in),
    .carry_in(carry_in), .reg_a_in(reg_a_in), .reg_b_in(reg_b_in),
    .reg_c_in(reg_c_in), .stack_rdata_in(stack_rdata_in), .wake_in(wake_in),
    .fetch_ready_out(fetch_ready_out), .insn_len_out(insn_len_out),
    .pc_out(pc_out), .sp_out(sp_out), .status_word_out(status_word_out),
    .busy_out(), .done_out(done_out), .cpu_clk_en_out(cpu_clk_en_out),
    .io_clk_en_out(io_clk_en_out), .dp_cmd_out(dp_cmd_out)
  );

  isd_stack_model stack_mdl (
    .clk_sys_in(clk_sys_in), .dp_cmd_in(dp_cmd_out),
    .stack_rdata_out(stack_rdata_in)
  );

  always @(posedge clk_sys_in)
    if (dp_cmd_out.reg_we === 1'b1)
      reg_seen[dp_cmd_out.reg_idx] <= dp_cmd_out.reg_data;

  task automatic print_verdict;
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int sel);
    return sel == 0 ? done_out : (sel == 1 ? cpu_clk_en_out : fetch_ready_out);
  endfunction

  task automatic wait_flag(input int sel, input logic val, input int lim,
    output int n);
    n = 0;
    while (pick(sel) !== val)
    begin
      @(negedge clk_sys_in);
      n++;
      if (n > lim)
      begin
        err_count++;
        $display("wrong value at %0t: wait ran out", $time);
        print_verdict();
      end
    end
  endtask

  task automatic issue(input logic [15:0] w, input logic [15:0] e1, input logic c);
    int n;
    wait_flag(2, 1'b1, 40, n);
    insn_word_in = w;
    ext1_in = e1;
    condition_field_true_in = c;
    insn_valid_in = 1'b1;
    @(negedge clk_sys_in);
    insn_valid_in = 1'b0;
  endtask

  // issue, wait for completion, let pc settle
  task automatic run(input logic [15:0] w, input logic [15:0] e1, input logic c,
    input logic [7:0] cyc, output int n);
    issue(w, e1, c);
    wait_flag(0, 1'b1, int'(cyc) + 4, n);
    @(negedge clk_sys_in);
  endtask

  task automatic t_jump;
    run(16'h5397, 16'hFFF0, 1'b1, CYC_JUMP_LONG_TAKEN, ct);
    check(pc_out, 16'hFFF4);
    check({14'h0000, insn_len_out}, 16'h0002);
    run(16'h5397, 16'hFFF0, 1'b0, CYC_JUMP_LONG_NOT, cn);
    check(pc_out, 16'hFFF8);
    check(16'(ct - cn), 16'h0003);
    run(16'h5F97, 16'h0100, 1'b0, CYC_JUMP_LONG_TAKEN, ct);
    check(pc_out, 16'h00FC);
  endtask

  task automatic t_mul(input logic [15:0] w, input logic [15:0] a,
    input logic [15:0] b, input logic [31:0] prod);
    int n;
    reg_a_in = a;
    reg_b_in = b;
    run(w, 16'h0000, 1'b0, CYC_MUL, n);
    repeat (3) @(negedge clk_sys_in);
    check(reg_seen[2], prod[31:16]);
    check(reg_seen[3], prod[15:0]);
    check(status_word_out, 16'h0000);
    check({14'h0000, insn_len_out}, 16'h0001);
  endtask

  // index register 2, destination register 1, word scaled
  task automatic t_lea;
    int n;
    reg_a_in = 16'h0010;
    run(16'h1291, 16'h0100, 1'b0, CYC_LEA, n);
    check(reg_seen[1], 16'h1120);
    check({14'h0000, insn_len_out}, 16'h0002);
  endtask

  task automatic t_neg;
    int n;
    reg_a_in = 16'h0005;
    carry_in = 1'b1;
    run(16'h37E5, 16'h0000, 1'b0, CYC_NEG_BORROW, n);
    check(reg_seen[5], 16'hFFFA);
    carry_in = 1'b0;
  endtask

  task automatic t_stack;
    reg_b_in = 16'hBEEF;
    run(OPC_PUSH_MULTI, 16'h000E, 1'b0, 8'h10, ct);
    check(sp_out, 16'hFFFA);
    run(OPC_PUSH_MULTI, 16'h0006, 1'b0, 8'h0D, cn);
    check(sp_out, 16'hFFF6);
    check(16'(ct - cn), 16'h0003);
    reg_seen[1] = 16'h0000;
    reg_seen[2] = 16'h0000;
    run(OPC_POP_MULTI, 16'h0006, 1'b0, 8'h0F, cn);
    check(sp_out, 16'hFFFA);
    check(reg_seen[1], 16'hBEEF);
    check(reg_seen[2], 16'hBEEF);
    run(OPC_POP_MULTI, 16'h000E, 1'b0, 8'h12, ct);
    check(sp_out, 16'h0000);
    check(16'(ct - cn), 16'h0003);
  endtask

  task automatic t_sleep(input logic [15:0] w, input logic io_on);
    int n;
    issue(w, 16'h0000, 1'b0);
    wait_flag(1, 1'b0, 10, n);
    check({15'h0000, io_clk_en_out}, {15'h0000, io_on});
    wake_in = 1'b1;
    @(negedge clk_sys_in);
    wake_in = 1'b0;
    wait_flag(1, 1'b1, 10, n);
    check({15'h0000, io_clk_en_out}, 16'h0001);
  endtask

  initial
  begin
    int n;
    repeat (2) @(negedge clk_sys_in);
    check(pc_out, RESET_PC);
    check({15'h0000, cpu_clk_en_out}, 16'h0001);
    arst_n_in = 1'b1;
    t_jump();
    t_mul(16'h5192, 16'h1234, 16'h0100, 32'h0012_3400);
    t_mul(16'h51B2, 16'hFFFF, 16'h0002, 32'hFFFF_FFFE);
    t_lea();
    t_neg();
    t_stack();
    run(OPC_INTERRUPT_RETURN, 16'h0000, 1'b0, CYC_INT_RETURN, n);
    check(status_word_out, 16'h5A00);
    check(pc_out, 16'h5A02);
    check(sp_out, 16'h0004);
    t_sleep(OPC_IDLE, 1'b1);
    check(pc_out, 16'h5A04);
    t_sleep(OPC_STOP, 1'b0);
    print_verdict();
  end
endmodule
